/* src/pff_pkg.sv */
// package for the pwm fault input filter block
package pff_pkg;
   localparam int unsigned PFF_NFLT = 4;
   // word indices of the registers; byte address is four times the index
   localparam logic [7:0] PFF_IDX_FILT0   = 8'h16;
   localparam logic [7:0] PFF_IDX_FILT1   = 8'h17;
   localparam logic [7:0] PFF_IDX_FILT2   = 8'h18;
   localparam logic [7:0] PFF_IDX_FILT3   = 8'h19;
   localparam logic [7:0] PFF_IDX_CONFIG  = 8'h1a;
   localparam logic [7:0] PFF_IDX_FCTRL   = 8'h1b;
   localparam logic [7:0] PFF_IDX_FSTAT   = 8'h1c;
   localparam logic [7:0] PFF_IDX_RCTRL   = 8'h1d;
   // filter configuration fields
   localparam int unsigned PFF_GSTR_BIT   = 15;
   localparam int unsigned PFF_CNT_LSB    = 8;
   localparam int unsigned PFF_CNT_W      = 3;
   localparam int unsigned PFF_PER_LSB    = 0;
   localparam int unsigned PFF_PER_W      = 8;
   localparam logic [3:0]  PFF_CNT_BASE   = 4'h3;
   localparam logic [15:0] PFF_FILT_RST   = 16'h0000;
   localparam logic [15:0] PFF_FILT_MASK  = 16'h87ff;
   // pwm config register: write protect bit
   localparam int unsigned PFF_WP_BIT     = 0;
   // reload control register fields
   localparam int unsigned PFF_RIE_BIT    = 0;
   localparam int unsigned PFF_RFLAG_BIT  = 1;
   // fault status register: flags in [3:0], pin levels in [7:4]
   localparam int unsigned PFF_FAULT_PIN_LEVEL_LSB   = 4;
   localparam int unsigned PFF_STRETCH    = 2;

   typedef struct packed {
      logic       glitch_stretch_en;
      logic [2:0] sample_count_sel;
      logic [7:0] sample_period_sel;
   } pff_filt_t;
endpackage : pff_pkg

/* src/pff_chan.sv */
// one fault input channel: synchroniser, stretcher, sampling filter
`timescale 1ns/100ps
module pff_chan
   import pff_pkg::*;
(
   // clock and reset
   input  wire logic            clock,
   input  wire logic            rstn,
   input  wire logic            ce,
   // configuration
   input  wire pff_pkg::pff_filt_t cfg,
   // fault pin and filtered level
   input  wire logic            pin,
   output logic                 level
);
   import pff_pkg::*;

   logic [2:0] sync_ff;
   logic       stable;
   logic [1:0] str_ff;
   logic       str_in;
   logic [7:0] per_ff;
   logic [3:0] cnt_ff;
   logic       level_ff;
   logic       smp_tick;
   logic       fi;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync_ff <= 3'h0;
      end else if (ce) begin
         // with stretch on, a rising edge in stage two is held one more clock so stages agree
         sync_ff[0] <= pin;
         sync_ff[1] <= sync_ff[0] |
                       (cfg.glitch_stretch_en & sync_ff[1] & ~sync_ff[2]);
         sync_ff[2] <= sync_ff[1];
      end
   end

   // change counts once second and third stage agree
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stable <= 1'b0;
      end else if (ce && (sync_ff[1] == sync_ff[2])) begin
         stable <= sync_ff[2];
      end
   end

   // active edge held high for at least two clocks
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         str_ff <= 2'h0;
      end else if (ce) begin
         str_ff <= stable ? 2'(PFF_STRETCH) : (str_ff != 2'h0 ? str_ff - 2'h1 : 2'h0);
      end
   end
   assign str_in = cfg.glitch_stretch_en ? (stable | (str_ff != 2'h0)) : stable;

   assign smp_tick = (per_ff == 8'h01);
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         per_ff <= 8'h00;
      end else if (ce) begin
         per_ff <= (smp_tick || per_ff == 8'h00) ? cfg.sample_period_sel : per_ff - 8'h01;
      end
   end

   // consecutive samples differing from the held level
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_ff   <= 4'h0;
         level_ff <= 1'b0;
      end else if (ce) begin
         if (cfg.sample_period_sel == 8'h00) begin
            cnt_ff   <= 4'h0;
            level_ff <= str_in;
         end else if (smp_tick) begin
            if (str_in == level_ff) begin
               cnt_ff <= 4'h0;
            end else if (cnt_ff + 4'h1 >= PFF_CNT_BASE + {1'b0, cfg.sample_count_sel}) begin
               cnt_ff   <= 4'h0;
               level_ff <= str_in;
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
            end
         end
      end
   end
   assign fi    = level_ff;
   assign level = fi;

   a_count_limit: assert property (@(posedge clock) disable iff (!rstn)
      cnt_ff <= 4'ha) else $error("sample counter beyond ten");
   a_bypass_pass: assert property (@(posedge clock) disable iff (!rstn)
      (ce && cfg.sample_period_sel == 8'h00 && !cfg.glitch_stretch_en) |=> level_ff == $past(stable))
      else $error("bypass did not pass input");
   a_stretch_two: assert property (@(posedge clock) disable iff (!rstn)
      (ce && $rose(stable) && cfg.glitch_stretch_en) ##1 ce |-> str_in)
      else $error("stretch shorter than two clocks");
endmodule : pff_chan

/* src/pff_top.sv */
// pwm fault input filter: registers, four filter channels, flags and shutdown
// Notes on behaviour
// - filter config writes ignored while the write-protect bit is set.
// - glitch stretch bit 15 holds an active fault edge two clocks.
// - stretching with filter off makes narrow pulses reach the fault flag.
// - transition accepted after count field plus three matching samples.
// - inputs sampled every sample period field clocks.
// - period field zero, the reset value, bypasses the filter.
// - pin status follows after up to (count+3) times period plus four clocks; the fault flag one clock later.
// - an unclocked path from each fault pin shuts the pwm outputs.
// - fault flag set on a rise of the filtered level; interrupt only if its enable set.
// - reload flag set each reload start; interrupt only if enabled.
// - system reset returns every register to its default.
// - the clock port carries the chosen pwm clock, system or triple.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module pff_top
   import pff_pkg::*;
(
   // clock (pwm clock chosen by system integration) and reset
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 ce,
   // avalon-mm slave
   input  wire logic [9:0]           address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   input  wire logic [3:0]           byteenable,
   output logic [31:0]               readdata,
   output logic                      waitrequest,
   // fault pins and pwm reload event
   input  wire logic [PFF_NFLT-1:0]  fault_input_pin,
   input  wire logic                 reload_start,
   // pwm shutdown and interrupts
   output logic                      pwm_disable,
   output logic                      fault_irq,
   output logic                      reload_irq
);
   import pff_pkg::*;

   pff_filt_t             filt_ff [PFF_NFLT];
   logic                  wp_ff;
   logic [PFF_NFLT-1:0]   fault_irq_en_ff;
   logic [PFF_NFLT-1:0]   fault_flag_ff;
   logic [PFF_NFLT-1:0]   fault_pin_level;
   logic [PFF_NFLT-1:0]   lvl_d_ff;
   logic                  reload_flag_ff;
   logic                  reload_irq_en_ff;
   logic                  ack_ff;
   logic [31:0]           readdata_ff;
   logic                  pwm_disable_ff;
   logic                  fault_irq_ff;
   logic                  reload_irq_ff;
   logic [7:0]            idx;
   logic                  acc;
   logic                  wr_go;
   logic [31:0]           nxt_rdata;
   logic [PFF_NFLT-1:0]   ack_clr;
   logic                  rld_clr;

   // one wait state: request taken when ack_ff is high
   assign idx   = address[9:2];
   assign acc   = (read | write) & ~ack_ff & ce;
   assign wr_go = write & ack_ff & ce;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= acc;
      end
   end
   assign waitrequest = ~ack_ff;

   genvar g;
   generate
      for (g = 0; g < PFF_NFLT; g++) begin : g_ch
         pff_chan u_chan (
            .clock (clock),
            .rstn  (rstn),
            .ce    (ce),
            .cfg   (filt_ff[g]),
            .pin   (fault_input_pin[g]),
            .level (fault_pin_level[g])
         );
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               filt_ff[g].glitch_stretch_en <= PFF_FILT_RST[PFF_GSTR_BIT];
               filt_ff[g].sample_count_sel  <= PFF_FILT_RST[PFF_CNT_LSB +: PFF_CNT_W];
               filt_ff[g].sample_period_sel <= PFF_FILT_RST[PFF_PER_LSB +: PFF_PER_W];
            end else if (wr_go && !wp_ff && idx == PFF_IDX_FILT0 + 8'(g)) begin
               if (byteenable[0]) begin
                  filt_ff[g].sample_period_sel <= writedata[PFF_PER_LSB +: PFF_PER_W];
               end
               if (byteenable[1]) begin
                  filt_ff[g].sample_count_sel  <= writedata[PFF_CNT_LSB +: PFF_CNT_W];
                  filt_ff[g].glitch_stretch_en <= writedata[PFF_GSTR_BIT];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wp_ff            <= 1'b0;
         fault_irq_en_ff  <= '0;
         reload_irq_en_ff <= 1'b0;
      end else if (wr_go && byteenable[0]) begin
         if (idx == PFF_IDX_CONFIG) begin
            wp_ff <= wp_ff | writedata[PFF_WP_BIT];
         end
         if (idx == PFF_IDX_FCTRL) begin
            fault_irq_en_ff <= writedata[PFF_NFLT-1:0];
         end
         if (idx == PFF_IDX_RCTRL) begin
            reload_irq_en_ff <= writedata[PFF_RIE_BIT];
         end
      end
   end

   // write one to clear; a set in the same cycle wins
   assign ack_clr = (wr_go && byteenable[0] && idx == PFF_IDX_FSTAT) ?
                    writedata[PFF_NFLT-1:0] : '0;
   assign rld_clr = wr_go && byteenable[0] && idx == PFF_IDX_RCTRL && writedata[PFF_RFLAG_BIT];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lvl_d_ff      <= '0;
         fault_flag_ff <= '0;
      end else if (ce) begin
         lvl_d_ff      <= fault_pin_level;
         fault_flag_ff <= (fault_flag_ff & ~ack_clr) | (fault_pin_level & ~lvl_d_ff);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reload_flag_ff <= 1'b0;
      end else if (ce) begin
         reload_flag_ff <= (reload_flag_ff & ~rld_clr) | reload_start;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fault_irq_ff  <= 1'b0;
         reload_irq_ff <= 1'b0;
      end else if (ce) begin
         fault_irq_ff  <= |(fault_flag_ff & fault_irq_en_ff);
         reload_irq_ff <= reload_flag_ff & reload_irq_en_ff;
      end
   end
   assign fault_irq  = fault_irq_ff;
   assign reload_irq = reload_irq_ff;

   // shutdown register follows the filtered levels on the clock; the raw pins are ORed after it, so pwm_disable acts without the clock
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pwm_disable_ff <= 1'b0;
      end else begin
         pwm_disable_ff <= |fault_pin_level;
      end
   end
   assign pwm_disable = pwm_disable_ff | (|fault_input_pin);

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (idx)
         PFF_IDX_FILT0: nxt_rdata[15:0] = {filt_ff[0].glitch_stretch_en, 4'h0,
            filt_ff[0].sample_count_sel, filt_ff[0].sample_period_sel} & PFF_FILT_MASK;
         PFF_IDX_FILT1: nxt_rdata[15:0] = {filt_ff[1].glitch_stretch_en, 4'h0,
            filt_ff[1].sample_count_sel, filt_ff[1].sample_period_sel} & PFF_FILT_MASK;
         PFF_IDX_FILT2: nxt_rdata[15:0] = {filt_ff[2].glitch_stretch_en, 4'h0,
            filt_ff[2].sample_count_sel, filt_ff[2].sample_period_sel} & PFF_FILT_MASK;
         PFF_IDX_FILT3: nxt_rdata[15:0] = {filt_ff[3].glitch_stretch_en, 4'h0,
            filt_ff[3].sample_count_sel, filt_ff[3].sample_period_sel} & PFF_FILT_MASK;
         PFF_IDX_CONFIG: nxt_rdata[PFF_WP_BIT] = wp_ff;
         PFF_IDX_FCTRL: nxt_rdata[PFF_NFLT-1:0] = fault_irq_en_ff;
         PFF_IDX_FSTAT: nxt_rdata[7:0] = {fault_pin_level, fault_flag_ff};
         PFF_IDX_RCTRL: nxt_rdata[1:0] = {reload_flag_ff, reload_irq_en_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         readdata_ff <= 32'h0000_0000;
      end else if (acc && read) begin
         readdata_ff <= nxt_rdata;
      end
   end
   assign readdata = readdata_ff;

   a_wp_blocks: assert property (@(posedge clock) disable iff (!rstn)
      (wr_go && wp_ff && idx == PFF_IDX_FILT0) |=> $stable(filt_ff[0]))
      else $error("protected filter register changed");
   a_flag_hold: assert property (@(posedge clock) disable iff (!rstn)
      (fault_flag_ff[0] && ack_clr[0] == 1'b0) |=> fault_flag_ff[0])
      else $error("fault flag lost without ack");
   a_fault_irq: assert property (@(posedge clock) disable iff (!rstn)
      (ce && |(fault_flag_ff & fault_irq_en_ff)) |=> fault_irq)
      else $error("fault irq missing");
   a_fault_noirq: assert property (@(posedge clock) disable iff (!rstn)
      (ce && fault_irq_en_ff == '0) |=> !fault_irq)
      else $error("fault irq without enable");
   a_reload_set: assert property (@(posedge clock) disable iff (!rstn)
      (ce && reload_start) |=> reload_flag_ff)
      else $error("reload flag not set");
   a_shutdown_pin: assert property (@(posedge clock) disable iff (!rstn)
      (|fault_input_pin) |-> pwm_disable)
      else $error("fault pin did not disable pwm");
endmodule : pff_top

/* dv/pff_fault_src.sv */
// fault pin source model standing for the power stage
`timescale 1ns/100ps
module pff_fault_src (
   // clock
   input  wire logic clock,
   // fault pins toward the device
   output logic [3:0] fault_input_pin
);
   initial fault_input_pin = 4'h0;
   // drive one pin level just after a rising edge
   task automatic set_pin(input int ch, input logic v);
      @(posedge clock);
      fault_input_pin[ch] <= v;
   endtask : set_pin
   // noise spike on one pin, held high for w clocks
   task automatic spike(input int ch, input int w);
      set_pin(ch, 1'b1);
      repeat (w - 1) @(posedge clock);
      set_pin(ch, 1'b0);
   endtask : spike
endmodule : pff_fault_src

/* dv/pff_top_test.sv */
// self-checking bench for the fault input filter
`timescale 1ns/100ps
module pff_top_test;
   import pff_pkg::*;
   logic        clock, rstn, read, write, waitrequest, reload_start;
   logic        pwm_disable, fault_irq, reload_irq;
   logic [9:0]  address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable, pins;
   int          n_errors, check_count, cyc;
   initial clock = 1'b0;
   always #2 clock = ~clock;
   pff_fault_src src_u (.clock(clock), .fault_input_pin(pins));
   pff_top dut_u (.clock(clock), .rstn(rstn), .ce(1'b1), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .fault_input_pin(pins), .reload_start(reload_start),
      .pwm_disable(pwm_disable), .fault_irq(fault_irq), .reload_irq(reload_irq));
   task automatic conclude;
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one avalon transfer held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      @(posedge clock);
      address   <= {idx, 2'b00};
      read      <= !wr;
      write     <= wr;
      writedata <= {16'h0000, d};
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wait_c(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_c
   task automatic t_reset;
      for (int i = 'h16; i <= 'h1d; i++) begin
         bus(1'b0, 8'(i), 16'h0000);
         chk(rd, 32'h0);
      end
      bus(1'b0, 8'h30, 16'h0000);
      chk(rd, 32'h0);
   endtask : t_reset
   task automatic t_fields;
      bus(1'b1, PFF_IDX_FILT1, 16'hffff);
      bus(1'b0, PFF_IDX_FILT1, 16'h0000);
      chk(rd, 32'h87ff);
      bus(1'b1, PFF_IDX_FILT1, 16'h0000);
   endtask : t_fields
   task automatic t_bypass;
      src_u.set_pin(0, 1'b1);
      #1 chk(pwm_disable, 1);
      wait_c(10);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h11);
      chk(fault_irq, 0);
      src_u.set_pin(0, 1'b0);
      wait_c(10);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h01);
      bus(1'b1, PFF_IDX_FCTRL, 16'h0001);
      wait_c(3);
      chk(fault_irq, 1);
      bus(1'b1, PFF_IDX_FSTAT, 16'h0001);
      wait_c(3);
      chk(fault_irq, 0);
   endtask : t_bypass
   task automatic t_filter;
      bus(1'b1, PFF_IDX_FILT3, 16'h0004);
      src_u.spike(3, 1);
      wait_c(40);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h0);
      src_u.set_pin(3, 1'b1);
      wait_c(9);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h0);
      wait_c(40);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h88);
      src_u.set_pin(3, 1'b0);
      wait_c(40);
      bus(1'b1, PFF_IDX_FSTAT, 16'h0008);
   endtask : t_filter
   task automatic t_stretch;
      bus(1'b1, PFF_IDX_FILT2, 16'h8000);
      src_u.spike(2, 1);
      wait_c(10);
      bus(1'b0, PFF_IDX_FSTAT, 16'h0000);
      chk(rd, 32'h04);
   endtask : t_stretch
   task automatic t_reload;
      @(posedge clock) reload_start <= 1'b1;
      @(posedge clock) reload_start <= 1'b0;
      wait_c(2);
      bus(1'b0, PFF_IDX_RCTRL, 16'h0000);
      chk(rd, 32'h2);
      chk(reload_irq, 0);
      bus(1'b1, PFF_IDX_RCTRL, 16'h0001);
      wait_c(3);
      chk(reload_irq, 1);
      bus(1'b1, PFF_IDX_RCTRL, 16'h0003);
      wait_c(3);
      chk(reload_irq, 0);
   endtask : t_reload
   task automatic t_protect;
      bus(1'b1, PFF_IDX_FILT0, 16'h0105);
      bus(1'b1, PFF_IDX_CONFIG, 16'h0001);
      bus(1'b1, PFF_IDX_FILT0, 16'h0203);
      bus(1'b0, PFF_IDX_FILT0, 16'h0000);
      chk(rd, 32'h0105);
      @(posedge clock) rstn <= 1'b0;
      wait_c(3);
      rstn <= 1'b1;
      t_reset();
   endtask : t_protect
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      rstn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 10'h000;
      writedata = 32'h0;
      byteenable = 4'hf;
      reload_start = 1'b0;
      wait_c(3);
      rstn <= 1'b1;
      t_reset();
      t_fields();
      t_bypass();
      t_filter();
      t_stretch();
      t_reload();
      t_protect();
      conclude();
   end
endmodule : pff_top_test
